/* hw/rsspi_pkg.sv */
// Package with constants, types and opcodes of the rate sensor serial command port.
package rsspi_pkg;

   // Byte and sample widths, and the FIFO depth.
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned SAMPLE_W = 10;
   localparam int unsigned FIFO_D   = 4;

   // Command opcodes.
   localparam logic [7:0] READ_RATE_HIGH_CMD    = 8'h80;
   localparam logic [7:0] READ_RATE_LOW_CMD     = 8'h8f;
   localparam logic [7:0] READ_STATUS_CMD       = 8'hb4;
   localparam logic [7:0] FILTER_INIT_CMD       = 8'hc4;
   localparam logic [7:0] UNLOCK_STEP_ONE_CMD   = 8'h4e;
   localparam logic [7:0] UNLOCK_STEP_TWO_CMD   = 8'h63;
   localparam logic [7:0] UNLOCK_STEP_THREE_CMD = 8'h12;
   localparam logic [7:0] RELOCK_CMD            = 8'h55;
   localparam logic [7:0] PROCESSING_REENABLE_CMD = 8'haa;

   // Address bytes that the unlock steps demand.
   localparam logic [7:0] UNLOCK_ONE_ADDR   = 8'hd7;
   localparam logic [7:0] UNLOCK_TWO_ADDR   = 8'h50;
   localparam logic [7:0] UNLOCK_THREE_ADDR = 8'ha8;

   // Answers and fixed patterns.
   localparam logic [7:0] ERROR_BYTE     = 8'h80;
   localparam logic [5:0] LOW_BYTE_FIXED = 6'h15;
   localparam logic [7:0] STATUS_ONES    = 8'h01;

   // Status flag roles: recoverable, latching non-recoverable, live only, and error-signalling.
   localparam logic [7:0] FLAG_RECOVERABLE = 8'h82;
   localparam logic [7:0] FLAG_STICKY_FATAL = 8'h68;
   localparam logic [7:0] FLAG_LIVE_ONLY   = 8'h04;
   localparam logic [7:0] FLAG_ERROR_MASK  = 8'hee;

   // Reset values.
   localparam logic [7:0] HELD_RESP_RESET = ERROR_BYTE;

   // Link pins after synchronisation.
   typedef struct packed {
      logic sclk;
      logic load_n;
      logic mosi;
   } rsspi_pins_t;

   // Progress through the unlock sequence.
   typedef enum logic [1:0] {
      UNLK_IDLE,
      UNLK_ONE,
      UNLK_TWO
   } rsspi_unlock_t;

endpackage : rsspi_pkg

/* hw/rsspi_port.sv */
// Sample FIFO and serial command port of the rate sensor.
`timescale 1ns/1ps

// Small FIFO between the rate datapath and the command port.
module rsspi_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset.
   input  wire logic             clk_sys_in,
   input  wire logic             reset_n_in,
   // Filling side.
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side.
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers wrap naturally only for a power-of-two depth.
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("rsspi_fifo: DEPTH must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   logic             push;
   logic             pop;

   // Full and empty come straight from the fill count.
   assign in_ready_out  = (count != DEPTH[PTR_W:0]);
   assign out_valid_out = (count != '0);
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign out_data_out  = mem[rd_ptr];

   // Storage is written without reset; only the pointers and the count need a defined state.
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // Pointer and count upkeep.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule : rsspi_fifo

module rsspi_port #(
   parameter int unsigned FIFO_DEPTH = rsspi_pkg::FIFO_D
) (
   // Clock and reset.
   input  wire logic                              clk_sys_in,
   input  wire logic                              reset_n_in,
   // Serial link pins.
   input  wire logic                              sclk_in,
   input  wire logic                              load_n_in,
   input  wire logic                              mosi_in,
   output logic                                   miso_out,
   output logic                                   miso_oe_out,
   // Rate samples from the datapath.
   input  wire logic                              sample_valid_in,
   output logic                                   sample_ready_out,
   input  wire logic [rsspi_pkg::SAMPLE_W-1:0]    sample_data_in,
   // Monitor flags and start-up state.
   input  wire logic [rsspi_pkg::BYTE_W-1:0]      status_flags_in,
   input  wire logic                              startup_done_in,
   // Control outputs towards the datapath.
   output logic                                   filter_init_hold_out,
   output logic                                   processing_hold_out,
   output logic                                   lock_enabled_out
);
   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("rsspi_port: FIFO_DEPTH must be at least 2");
      end
   end

   rsspi_pkg::rsspi_pins_t sync1;
   rsspi_pkg::rsspi_pins_t sync2;
   rsspi_pkg::rsspi_pins_t sync3;
   rsspi_pkg::rsspi_pins_t pins;
   rsspi_pkg::rsspi_pins_t next_pins;

   logic [7:0]  cmd_shift;
   logic [7:0]  out_shift;
   logic [3:0]  bit_count;
   logic [7:0]  addr_byte;
   logic [7:0]  held_resp;
   logic [7:0]  next_resp;
   logic [1:0]  low_bits;
   logic        low_err;
   logic        unlocked;
   logic [7:0]  sticky_err;
   logic [9:0]  cur_sample;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        load_fall;
   logic        load_rise;
   logic        execute;
   logic        rate_err;
   logic [7:0]  status_byte;
   logic        fifo_valid;
   logic        fifo_drain;
   logic [9:0]  fifo_data;
   rsspi_pkg::rsspi_unlock_t unlock_step;

   // Three-stage synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         sync1 <= '{sclk: 1'b0, load_n: 1'b1, mosi: 1'b0};
         sync2 <= '{sclk: 1'b0, load_n: 1'b1, mosi: 1'b0};
         sync3 <= '{sclk: 1'b0, load_n: 1'b1, mosi: 1'b0};
      end else begin
         sync1 <= '{sclk: sclk_in, load_n: load_n_in, mosi: mosi_in};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // A pin level is accepted only once stages two and three agree, which rejects a single glitch.
   always_comb begin
      next_pins = pins;
      if (sync2.sclk == sync3.sclk) begin
         next_pins.sclk = sync2.sclk;
      end
      if (sync2.load_n == sync3.load_n) begin
         next_pins.load_n = sync2.load_n;
      end
      if (sync2.mosi == sync3.mosi) begin
         next_pins.mosi = sync2.mosi;
      end
   end

   // Filtered pin levels.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         pins <= '{sclk: 1'b0, load_n: 1'b1, mosi: 1'b0};
      end else begin
         pins <= next_pins;
      end
   end

   // Edge events, each one system cycle long.
   assign sclk_rise = next_pins.sclk && !pins.sclk && !pins.load_n;
   assign sclk_fall = !next_pins.sclk && pins.sclk && !pins.load_n;
   assign load_fall = !next_pins.load_n && pins.load_n;
   assign load_rise = next_pins.load_n && !pins.load_n;
   assign execute   = load_rise && (bit_count >= 4'd8);

   // Command shift register and bit counter; the count saturates so long frames still execute.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         cmd_shift <= 8'h00;
         bit_count <= 4'h0;
      end else if (load_fall) begin
         bit_count <= 4'h0;
      end else if (sclk_rise) begin
         cmd_shift <= {cmd_shift[6:0], next_pins.mosi};
         if (bit_count != 4'd8) begin
            bit_count <= bit_count + 4'h1;
         end
      end
   end

   // Output shifter: loaded at select fall, advanced on each clock fall.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         out_shift <= rsspi_pkg::HELD_RESP_RESET;
      end else if (load_fall) begin
         out_shift <= held_resp;
      end else if (sclk_fall) begin
         out_shift <= {out_shift[6:0], 1'b0};
      end
   end

   // Pin drive; the enable tracks the filtered select, so it lags the pin by the sync delay.
   assign miso_out    = out_shift[7];
   assign miso_oe_out = !pins.load_n;

   // The last full byte is kept as the address for the command that follows.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         addr_byte <= 8'h00;
      end else if (execute) begin
         addr_byte <= cmd_shift;
      end
   end

   // Sample stream buffer; draining stops during a frame or while processing is held.
   rsspi_fifo #(
      .WIDTH (rsspi_pkg::SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (sample_valid_in),
      .in_ready_out  (sample_ready_out),
      .in_data_in    (sample_data_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_drain),
      .out_data_out  (fifo_data)
   );

   assign fifo_drain = pins.load_n && !processing_hold_out;

   // Current two's-complement sample, one LSB per degree per second.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         cur_sample <= 10'h000;
      end else if (fifo_valid && fifo_drain) begin
         cur_sample <= fifo_data;
      end
   end

   // Latched monitor errors; nothing latches while unlocked or during start-up.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         sticky_err <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (!unlocked && startup_done_in && !status_flags_in[i] &&
                (rsspi_pkg::FLAG_RECOVERABLE[i] || rsspi_pkg::FLAG_STICKY_FATAL[i])) begin
               sticky_err[i] <= 1'b1;
            end else if (execute && cmd_shift == rsspi_pkg::PROCESSING_REENABLE_CMD &&
                         unlocked && rsspi_pkg::FLAG_RECOVERABLE[i]) begin
               sticky_err[i] <= 1'b0;
            end
         end
      end
   end

   assign processing_hold_out = (sticky_err != 8'h00);

   // Readout is invalid during start-up, on any latched error, or on a live zero flag within FLAG_ERROR_MASK.
   assign rate_err = !startup_done_in || processing_hold_out ||
                     ((~status_flags_in & rsspi_pkg::FLAG_ERROR_MASK) != 8'h00);
   assign status_byte = status_flags_in | rsspi_pkg::STATUS_ONES;

   // Unlock sequence: stray non-opcode bytes are taken as addresses and leave the step alone.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         unlock_step <= rsspi_pkg::UNLK_IDLE;
         unlocked    <= 1'b0;
      end else if (execute) begin
         unique case (cmd_shift)
            rsspi_pkg::UNLOCK_STEP_ONE_CMD: begin
               unlock_step <= (addr_byte == rsspi_pkg::UNLOCK_ONE_ADDR) ?
                              rsspi_pkg::UNLK_ONE : rsspi_pkg::UNLK_IDLE;
            end
            rsspi_pkg::UNLOCK_STEP_TWO_CMD: begin
               unlock_step <= (unlock_step == rsspi_pkg::UNLK_ONE &&
                               addr_byte == rsspi_pkg::UNLOCK_TWO_ADDR) ?
                              rsspi_pkg::UNLK_TWO : rsspi_pkg::UNLK_IDLE;
            end
            rsspi_pkg::UNLOCK_STEP_THREE_CMD: begin
               if (unlock_step == rsspi_pkg::UNLK_TWO &&
                   addr_byte == rsspi_pkg::UNLOCK_THREE_ADDR) begin
                  unlocked <= 1'b1;
               end
               unlock_step <= rsspi_pkg::UNLK_IDLE;
            end
            rsspi_pkg::RELOCK_CMD: begin
               unlocked    <= 1'b0;
               unlock_step <= rsspi_pkg::UNLK_IDLE;
            end
            rsspi_pkg::READ_RATE_HIGH_CMD,
            rsspi_pkg::READ_RATE_LOW_CMD,
            rsspi_pkg::READ_STATUS_CMD,
            rsspi_pkg::FILTER_INIT_CMD,
            rsspi_pkg::PROCESSING_REENABLE_CMD: begin
               unlock_step <= rsspi_pkg::UNLK_IDLE;
            end
            default: begin
               unlock_step <= unlock_step;
            end
         endcase
      end
   end

   assign lock_enabled_out = !unlocked;

   // Filter initialisation hold, honoured only while unlocked.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         filter_init_hold_out <= 1'b0;
      end else if (execute && cmd_shift == rsspi_pkg::FILTER_INIT_CMD && unlocked) begin
         filter_init_hold_out <= (addr_byte != 8'h00);
      end
   end

   // Low bits of the sample are frozen by the high-byte read so a pair stays coherent.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         low_bits <= 2'b00;
         low_err  <= 1'b1;
      end else if (execute && cmd_shift == rsspi_pkg::READ_RATE_HIGH_CMD) begin
         low_bits <= cur_sample[1:0];
         low_err  <= rate_err;
      end
   end

   // Answer for the command being executed.
   always_comb begin
      next_resp = rsspi_pkg::ERROR_BYTE;
      unique case (cmd_shift)
         rsspi_pkg::READ_RATE_HIGH_CMD: begin
            next_resp = rate_err ? rsspi_pkg::ERROR_BYTE : cur_sample[9:2];
         end
         rsspi_pkg::READ_RATE_LOW_CMD: begin
            next_resp = (rate_err || low_err) ? rsspi_pkg::ERROR_BYTE :
                        {rsspi_pkg::LOW_BYTE_FIXED, low_bits};
         end
         rsspi_pkg::READ_STATUS_CMD: begin
            next_resp = status_byte;
         end
         default: begin
            next_resp = rsspi_pkg::ERROR_BYTE;
         end
      endcase
   end

   // Held answer goes out in the next frame; reset leaves the error byte in it.
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         held_resp <= rsspi_pkg::HELD_RESP_RESET;
      end else if (execute) begin
         held_resp <= next_resp;
      end
   end

endmodule : rsspi_port

/* testbench/rsspi_host_model.sv */
// Host-side serial master that frames commands towards the port.
`timescale 1ns/1ps
module rsspi_host_model (
   // Link pins towards the port.
   output logic      sclk_out,
   output logic      load_n_out,
   output logic      mosi_out,
   // Data-out pin of the port and its enable.
   input  wire logic miso_in,
   input  wire logic miso_oe_in
);
   localparam realtime HALF = 62.5;
   logic last = 1'b0;
   // A released line shows the inverse of its last level, so stale data never reads as valid.
   wire logic miso_pin = miso_oe_in ? miso_in : ~last;

   // Track the last driven level of the data-out line.
   always @(miso_in or miso_oe_in) if (miso_oe_in) last = miso_in;

   // Link idles with the clock low and the port deselected.
   initial begin
      sclk_out   = 1'b0;
      load_n_out = 1'b1;
      mosi_out   = 1'b0;
   end

   // One frame of nbits; the clock only runs inside frames.
   task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] resp);
      resp = 8'h00;
      load_n_out = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         #(HALF / 2) mosi_out = cmd[7-i];
         #(HALF / 2) sclk_out = 1'b1;
         resp = {resp[6:0], miso_pin};
         #HALF sclk_out = 1'b0;
      end
      #HALF load_n_out = 1'b1;
      mosi_out = ~mosi_out;
      #600;
   endtask : xfer
endmodule : rsspi_host_model

/* testbench/rsspi_port_bench.sv */
// Self-checking bench of the rate sensor serial command port.
`timescale 1ns/1ps
module rsspi_port_bench;
   localparam logic [7:0] ERR = rsspi_pkg::ERROR_BYTE;
   logic                            clk_sys_in, reset_n_in, sclk_in, load_n_in, mosi_in;
   logic                            sample_valid_in, startup_done_in, sample_ready_out;
   logic [rsspi_pkg::SAMPLE_W-1:0] sample_data_in;
   logic [7:0]                      status_flags_in;
   logic                            miso_out, miso_oe_out, lock_enabled_out;
   logic                            filter_init_hold_out, processing_hold_out;
   int                              error_cnt, checks_done;

   rsspi_port #(.FIFO_DEPTH(rsspi_pkg::FIFO_D)) i_dut (.*);
   rsspi_host_model i_host (.sclk_out(sclk_in), .load_n_out(load_n_in), .mosi_out(mosi_in),
      .miso_in(miso_out), .miso_oe_in(miso_oe_out));

   // System clock.
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // A frame whose answer belongs to the frame before it.
   task automatic run(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] r;
      i_host.xfer(c, 8, r);
      chk(r, exp);
   endtask : run

   task automatic push(input logic [9:0] d);
      @(posedge clk_sys_in);
      sample_valid_in <= 1'b1;
      sample_data_in  <= d;
      @(posedge clk_sys_in);
      sample_valid_in <= 1'b0;
      repeat (10) @(posedge clk_sys_in);
   endtask : push

   // A monitor flag drops for a short while and comes back.
   task automatic fault;
      @(posedge clk_sys_in);
      status_flags_in <= 8'h6e;
      repeat (20) @(posedge clk_sys_in);
      status_flags_in <= 8'hee;
      repeat (4) @(posedge clk_sys_in);
   endtask : fault

   task automatic unlock(input logic [7:0] a2, input logic [7:0] mid);
      run(8'hd7, ERR);
      run(8'h4e, ERR);
      run(a2, ERR);
      run(8'h63, ERR);
      if (mid != 8'h00) run(mid, ERR);
      run(8'ha8, ERR);
      run(8'h12, ERR);
   endtask : unlock

   task automatic t_startup;
      chk({3'h0, sample_ready_out, miso_oe_out, filter_init_hold_out, processing_hold_out,
         lock_enabled_out}, 8'h11);
      run(8'hb4, ERR);
      run(8'h80, 8'hef);
      run(8'h8f, ERR);
      run(8'hb4, ERR);
   endtask : t_startup

   task automatic t_rate;
      logic [7:0] r;
      @(posedge clk_sys_in);
      startup_done_in <= 1'b1;
      push(10'h2a6);
      run(8'h80, 8'hef);
      push(10'h0f1);
      run(8'h8f, 8'ha9);
      run(8'h80, 8'h56);
      run(8'h00, 8'h3c);
      run(8'hff, ERR);
      run(8'hb4, ERR);
      i_host.xfer(8'h8f, 5, r);
      run(8'h01, 8'hef);
      run(8'hc4, ERR);
      chk(8'(filter_init_hold_out), 8'h00);
   endtask : t_rate

   task automatic t_unlock;
      unlock(8'h50, 8'h55);
      chk(8'(lock_enabled_out), 8'h01);
      unlock(8'h51, 8'h00);
      chk(8'(lock_enabled_out), 8'h01);
      unlock(8'h50, 8'h00);
      chk(8'(lock_enabled_out), 8'h00);
      run(8'h01, ERR);
      run(8'hc4, ERR);
      chk(8'(filter_init_hold_out), 8'h01);
      run(8'h00, ERR);
      run(8'hc4, ERR);
      chk(8'(filter_init_hold_out), 8'h00);
   endtask : t_unlock

   task automatic t_recover;
      int n;
      fault();
      chk(8'(processing_hold_out), 8'h00);
      run(8'h55, ERR);
      chk(8'(lock_enabled_out), 8'h01);
      fault();
      run(8'h80, ERR);
      run(8'hb4, ERR);
      // While processing is held the buffer is not drained, so it must fill up and refuse.
      n = 0;
      @(posedge clk_sys_in);
      sample_valid_in <= 1'b1;
      repeat (8) begin
         @(negedge clk_sys_in);
         if (sample_ready_out) n++;
         @(posedge clk_sys_in);
      end
      sample_valid_in <= 1'b0;
      chk(8'(n), 8'(rsspi_pkg::FIFO_D));
      // The status read above leaves its byte in the held answer, so collect it first.
      run(8'h80, 8'hef);
      unlock(8'h50, 8'h00);
      run(8'haa, ERR);
      chk(8'(processing_hold_out), 8'h00);
      repeat (20) @(posedge clk_sys_in);
      chk(8'(sample_ready_out), 8'h01);
      run(8'h55, ERR);
   endtask : t_recover

   task automatic print_verdict;
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // Watchdog: the whole sequence needs well under 150 us.
   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      error_cnt = 0;
      checks_done = 0;
      reset_n_in = 1'b0;
      sample_valid_in = 1'b0;
      sample_data_in = 10'h000;
      startup_done_in = 1'b0;
      status_flags_in = 8'hee;
      repeat (8) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      t_startup();
      t_rate();
      t_unlock();
      t_recover();
      print_verdict();
   end
endmodule : rsspi_port_bench

/* testbench/rsspi_port_chk.sv */
// Checker of the serial command port's pin and control behaviour.
`timescale 1ns/1ps
module rsspi_port_chk (
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Link pins.
   input wire logic sclk_in,
   input wire logic load_n_in,
   input wire logic miso_out,
   input wire logic miso_oe_out,
   // Control outputs.
   input wire logic filter_init_hold_out,
   input wire logic processing_hold_out,
   input wire logic lock_enabled_out
);
   // One domain, so clock and reset are given once for every property.
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   // The pin filter delays the select by a few cycles, so seven cycles are allowed.
   a_miso_released: assert property (load_n_in [*7] |-> !miso_oe_out)
      else $error("data-out driven while deselected");
   a_miso_driven: assert property ((!load_n_in) [*7] |-> miso_oe_out)
      else $error("data-out not driven while selected");
   a_reset_values: assert property ($rose(reset_n_in) |-> lock_enabled_out
      && !miso_oe_out && !filter_init_hold_out && !processing_hold_out)
      else $error("wrong state after reset");
   a_miso_steady: assert property (miso_oe_out && sclk_in && $past(sclk_in, 8)
      |-> $stable(miso_out))
      else $error("data-out moved while serial clock high");
   a_filter_unlocked: assert property ($changed(filter_init_hold_out) |-> !lock_enabled_out)
      else $error("filter hold changed while locked");
   a_exec_gap: assert property ($changed(lock_enabled_out)
      |-> load_n_in && $past(load_n_in, 2))
      else $error("lock changed inside a frame");
   a_clear_unlocked: assert property ($fell(processing_hold_out) |-> !lock_enabled_out)
      else $error("error cleared while locked");
   a_latch_locked: assert property ($rose(processing_hold_out) |-> $past(lock_enabled_out))
      else $error("error latched while unlocked");
endmodule : rsspi_port_chk

bind rsspi_port rsspi_port_chk i_chk (.*);
